// >>> inc/cad_pkg.sv
// shared constants, types and helpers for the address-mode decoder
package cad_pkg;

  localparam int CAD_ADDR_W = 16;
  localparam int CAD_DATA_W = 8;
  localparam int CAD_OPCODE_SPACE = 256;
  localparam int CAD_OP_COUNT = 63;
  localparam int CAD_GROUP_COUNT = 13;

  localparam logic [7:0] CAD_Y_REGISTER_PREFIX = 8'h90;
  localparam logic [7:0] CAD_Y_INDIRECT_INDEXED_PREFIX = 8'h91;
  localparam logic [7:0] CAD_INDIRECT_PREFIX = 8'h92;
  localparam logic [7:0] CAD_RELATIVE_SUBROUTINE_CALL = 8'had;

  // opcode rows (upper nibble)
  localparam logic [3:0] CAD_ROW_BITREL = 4'h0;
  localparam logic [3:0] CAD_ROW_BIT = 4'h1;
  localparam logic [3:0] CAD_ROW_REL = 4'h2;
  localparam logic [3:0] CAD_ROW_RMW_DIR = 4'h3;
  localparam logic [3:0] CAD_ROW_INH_A = 4'h4;
  localparam logic [3:0] CAD_ROW_INH_X = 4'h5;
  localparam logic [3:0] CAD_ROW_RMW_IDX1 = 4'h6;
  localparam logic [3:0] CAD_ROW_RMW_IDX0 = 4'h7;
  localparam logic [3:0] CAD_ROW_MISC_A = 4'h8;
  localparam logic [3:0] CAD_ROW_MISC_B = 4'h9;
  localparam logic [3:0] CAD_ROW_IMM = 4'ha;
  localparam logic [3:0] CAD_ROW_DIR = 4'hb;
  localparam logic [3:0] CAD_ROW_DIR_LONG = 4'hc;
  localparam logic [3:0] CAD_ROW_IDX_LONG = 4'hd;
  localparam logic [3:0] CAD_ROW_IDX1 = 4'he;
  localparam logic [3:0] CAD_ROW_IDX0 = 4'hf;

  // alu-row columns that only exist in short indirect form
  localparam logic [3:0] CAD_COL_JUMP = 4'hc;
  localparam logic [3:0] CAD_COL_CALL = 4'hd;

  localparam logic [1:0] CAD_LEN_RESET = 2'h0;

  typedef enum logic [1:0] {
    CAD_PFX_NONE, CAD_PFX_Y, CAD_PFX_IND, CAD_PFX_YIND
  } cad_prefix_type;

  typedef enum logic [4:0] {
    CAD_INHERENT, CAD_IMMEDIATE, CAD_DIR_SHORT, CAD_DIR_LONG,
    CAD_IDX0, CAD_IDX_SHORT, CAD_IDX_LONG, CAD_IND_SHORT, CAD_IND_LONG,
    CAD_INDIDX_SHORT, CAD_INDIDX_LONG, CAD_REL_DIR, CAD_REL_IND,
    CAD_BIT_DIR, CAD_BIT_IND, CAD_BITREL_DIR, CAD_BITREL_IND
  } cad_mode_type;

  typedef enum logic [3:0] {
    CAD_GRP_LOAD, CAD_GRP_STACK, CAD_GRP_INC_DEC, CAD_GRP_COMPARE,
    CAD_GRP_LOGICAL, CAD_GRP_BIT, CAD_GRP_BIT_BRANCH, CAD_GRP_ARITH,
    CAD_GRP_SHIFT, CAD_GRP_JUMP, CAD_GRP_COND_BRANCH, CAD_GRP_INTERRUPT,
    CAD_GRP_FLAG
  } cad_group_type;

  // bytes after the opcode for a final mode
  function automatic logic [1:0] cad_mode_bytes(input cad_mode_type m);
    case (m)
      CAD_INHERENT, CAD_IDX0: cad_mode_bytes = 2'd0;
      CAD_DIR_LONG, CAD_IDX_LONG: cad_mode_bytes = 2'd2;
      CAD_BITREL_DIR, CAD_BITREL_IND: cad_mode_bytes = 2'd2;
      default: cad_mode_bytes = 2'd1;
    endcase
  endfunction

  // pointer bytes fetched from memory for a final mode
  function automatic logic [1:0] cad_mode_reads(input cad_mode_type m);
    case (m)
      CAD_IND_LONG, CAD_INDIDX_LONG: cad_mode_reads = 2'd2;
      CAD_IND_SHORT, CAD_INDIDX_SHORT, CAD_REL_IND: cad_mode_reads = 2'd1;
      CAD_BIT_IND, CAD_BITREL_IND: cad_mode_reads = 2'd1;
      default: cad_mode_reads = 2'd0;
    endcase
  endfunction

  function automatic logic [15:0] cad_sext8(input logic [7:0] v);
    cad_sext8 = {{8{v[7]}}, v};
  endfunction

endpackage

// >>> hw/cad_opcode_class.sv
// combinational opcode classifier: prefix and opcode to mode and group
`timescale 1ns/1ps
module cad_opcode_class
  import cad_pkg::*;
(
  input wire cad_prefix_type i_prefix,
  input wire logic [7:0] i_opcode,
  output cad_mode_type o_mode,
  output cad_group_type o_group,
  output logic o_use_y,
  output logic o_illegal,
  output logic [1:0] o_bytes,
  output logic [1:0] o_reads
);

  function automatic cad_group_type rmw_group(input logic [3:0] c);
    case (c)
      4'h0, 4'h3: rmw_group = CAD_GRP_LOGICAL;
      4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'he: rmw_group = CAD_GRP_SHIFT;
      4'ha, 4'hc: rmw_group = CAD_GRP_INC_DEC;
      4'hd: rmw_group = CAD_GRP_COMPARE;
      4'h2: rmw_group = CAD_GRP_ARITH;
      default: rmw_group = CAD_GRP_LOAD;
    endcase
  endfunction

  function automatic cad_group_type alu_group(input logic [3:0] c);
    case (c)
      4'h0, 4'h2, 4'h9, 4'hb: alu_group = CAD_GRP_ARITH;
      4'h1, 4'h3, 4'h5: alu_group = CAD_GRP_COMPARE;
      4'h4, 4'h8, 4'ha: alu_group = CAD_GRP_LOGICAL;
      4'hc, 4'hd: alu_group = CAD_GRP_JUMP;
      default: alu_group = CAD_GRP_LOAD;
    endcase
  endfunction

  logic [3:0] row;
  logic [3:0] col;
  cad_mode_type base;
  logic rmw_short_only;

  assign row = i_opcode[7:4];
  assign col = i_opcode[3:0];
  // read-modify-write, bit, shift, call and jump have no long indirect form
  assign rmw_short_only = !(row inside {CAD_ROW_IMM, CAD_ROW_DIR,
    CAD_ROW_DIR_LONG, CAD_ROW_IDX_LONG, CAD_ROW_IDX1, CAD_ROW_IDX0})
    || col == CAD_COL_JUMP || col == CAD_COL_CALL;

  always_comb
  begin
    base = CAD_INHERENT;
    o_group = CAD_GRP_LOAD;
    o_use_y = 1'b0;
    o_illegal = 1'b0;
    if (i_opcode == CAD_RELATIVE_SUBROUTINE_CALL)
    begin
      base = CAD_REL_DIR; // see RULE10
      o_group = CAD_GRP_JUMP;
    end
    else
    begin
      case (row)
        CAD_ROW_BITREL:
        begin
          base = CAD_BITREL_DIR;
          o_group = CAD_GRP_BIT_BRANCH;
        end
        CAD_ROW_BIT:
        begin
          base = CAD_BIT_DIR;
          o_group = CAD_GRP_BIT;
        end
        CAD_ROW_REL:
        begin
          base = CAD_REL_DIR; // see RULE10
          o_group = CAD_GRP_COND_BRANCH;
        end
        CAD_ROW_RMW_DIR, CAD_ROW_RMW_IDX1, CAD_ROW_RMW_IDX0:
        begin
          base = (row == CAD_ROW_RMW_DIR) ? CAD_DIR_SHORT :
                 (row == CAD_ROW_RMW_IDX1) ? CAD_IDX_SHORT : CAD_IDX0;
          o_group = rmw_group(col);
        end
        CAD_ROW_INH_A, CAD_ROW_INH_X: o_group = rmw_group(col);
        CAD_ROW_MISC_A:
          o_group = (col inside {4'h0, 4'h3, 4'he, 4'hf}) ?
                    CAD_GRP_INTERRUPT : CAD_GRP_STACK;
        CAD_ROW_MISC_B:
          o_group = (col inside {4'h8, 4'h9, 4'ha, 4'hb}) ?
                    CAD_GRP_FLAG : CAD_GRP_LOAD;
        CAD_ROW_IMM:
        begin
          base = CAD_IMMEDIATE;
          o_group = alu_group(col);
          o_illegal = col inside {4'h7, 4'hc, 4'hd, 4'hf};
        end
        CAD_ROW_DIR: base = CAD_DIR_SHORT;
        CAD_ROW_DIR_LONG: base = CAD_DIR_LONG; // see RULE1
        CAD_ROW_IDX_LONG: base = CAD_IDX_LONG;
        CAD_ROW_IDX1: base = CAD_IDX_SHORT;
        default: base = CAD_IDX0;
      endcase
      if (row >= CAD_ROW_DIR)
        o_group = alu_group(col);
    end
    o_mode = base;
    case (i_prefix)
      CAD_PFX_Y: // see RULE18
      begin
        o_use_y = 1'b1;
        o_illegal = o_illegal || !(base inside {CAD_IMMEDIATE, CAD_INHERENT,
          CAD_DIR_SHORT, CAD_DIR_LONG, CAD_IDX0, CAD_IDX_SHORT, CAD_IDX_LONG});
      end
      CAD_PFX_IND: // see RULE19 RULE20
      begin
        case (base)
          CAD_DIR_SHORT: o_mode = CAD_IND_SHORT;
          CAD_DIR_LONG: o_mode = CAD_IND_LONG;
          CAD_IDX_SHORT: o_mode = CAD_INDIDX_SHORT;
          CAD_IDX_LONG: o_mode = CAD_INDIDX_LONG;
          CAD_BIT_DIR: o_mode = CAD_BIT_IND;
          CAD_BITREL_DIR: o_mode = CAD_BITREL_IND;
          CAD_REL_DIR: o_mode = CAD_REL_IND;
          default: o_illegal = 1'b1;
        endcase
        // see RULE11 RULE12 RULE13
        if ((base == CAD_DIR_LONG || base == CAD_IDX_LONG) && rmw_short_only)
          o_illegal = 1'b1;
      end
      CAD_PFX_YIND: // see RULE21
      begin
        o_use_y = 1'b1;
        case (base)
          CAD_IDX_SHORT: o_mode = CAD_INDIDX_SHORT;
          CAD_IDX_LONG: o_mode = CAD_INDIDX_LONG;
          default: o_illegal = 1'b1;
        endcase
        if (base == CAD_IDX_LONG && rmw_short_only)
          o_illegal = 1'b1; // see RULE13
      end
      default: o_use_y = 1'b0;
    endcase
    o_bytes = cad_mode_bytes(o_mode);
    o_reads = cad_mode_reads(o_mode);
  end

endmodule

// >>> hw/cad_decoder.sv
// address-mode and prefix decoder between fetch stream and address unit
//
// Contract
// RULE1: long indexed takes a 16-bit offset from the two bytes after opcode.
// RULE2: indirect modes read the operand address from a pointer in memory.
// RULE3: short indirect uses a one-byte pointer, operand in 00 to FF.
// RULE4: long indirect forms use a 16-bit pointer reaching all 64Kb.
// RULE5: indirect indexed adds index register and fetched pointer, unsigned.
// RULE6: short indirect indexed spans 00 to 1FE, one byte after opcode.
// RULE7: relative modes add a signed 8-bit offset to the program counter.
// RULE8: direct relative takes the offset from the byte after the opcode.
// RULE9: indirect relative reads the offset from memory at that byte.
// RULE10: only conditional jumps and relative calls use relative modes.
// RULE11: load, compare, logic, arithmetic, bit compare allow long indirect.
// RULE12: read-modify-write, bit, shift, call, jump allow only short indirect.
// RULE13: same short-only limit applies in indirect indexed mode.
// RULE14: sixty-three operations in thirteen functional groups.
// RULE15: three prefix bytes extend the 256-entry opcode space.
// RULE16: layout is optional prefix, opcode, then zero to two bytes.
// RULE17: prefixes precede X-based or direct opcodes for Y and indirect.
// RULE18: prefix 90 turns X-based forms into Y-based forms.
// RULE19: prefix 92 turns direct, bit and relative forms into indirect.
// RULE20: prefix 92 turns X indexed into indirect X indexed.
// RULE21: prefix 91 turns X indirect indexed into Y indirect indexed.
// RULE22: indexed address is unsigned index plus the following offset.
// RULE23: a prefix affects only the next opcode and clears afterwards.
// RULE24: length is prefix plus opcode plus the mode's operand bytes.
`timescale 1ns/1ps
module cad_decoder
  import cad_pkg::*;
#(
  parameter int ADDR_W = CAD_ADDR_W,
  parameter int DATA_W = CAD_DATA_W
)
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_fetch_valid,
  input wire logic [DATA_W-1:0] i_fetch_byte,
  input wire logic [ADDR_W-1:0] i_fetch_pc,
  output logic o_fetch_ready,
  input wire logic [DATA_W-1:0] i_index_x,
  input wire logic [DATA_W-1:0] i_index_y,
  output logic o_mem_req,
  output logic [ADDR_W-1:0] o_mem_addr,
  input wire logic i_mem_ack,
  input wire logic [DATA_W-1:0] i_mem_data,
  output logic o_done,
  output logic [DATA_W-1:0] o_opcode,
  output cad_mode_type o_mode,
  output cad_group_type o_group,
  output logic o_use_y,
  output logic o_illegal,
  output logic [2:0] o_length,
  output logic [ADDR_W-1:0] o_eff_addr,
  output logic [DATA_W-1:0] o_immediate,
  output logic o_branch,
  output logic [ADDR_W-1:0] o_branch_target
);

  typedef enum logic [1:0] {
    CAD_ST_OPCODE, CAD_ST_OPERAND, CAD_ST_POINTER, CAD_ST_FINISH
  } cad_state_type;

  typedef struct packed {
    cad_state_type st;
    cad_prefix_type prefix;
    logic [ADDR_W-1:0] start_pc;
    logic [DATA_W-1:0] opcode;
    logic [DATA_W-1:0] byte1;
    logic [DATA_W-1:0] byte2;
    logic [DATA_W-1:0] ptr_hi;
    logic [DATA_W-1:0] ptr_lo;
    logic [1:0] count;
    logic double_prefix;
    logic done;
    logic [DATA_W-1:0] out_opcode;
    cad_mode_type mode;
    cad_group_type group;
    logic use_y;
    logic illegal;
    logic [2:0] length;
    logic [ADDR_W-1:0] eff_addr;
    logic [DATA_W-1:0] immediate;
    logic branch;
    logic [ADDR_W-1:0] branch_target;
  } cad_regs_type;

  cad_regs_type s;
  cad_regs_type next_s;

  cad_mode_type cls_mode;
  cad_group_type cls_group;
  logic cls_use_y;
  logic cls_illegal;
  logic [1:0] cls_bytes;
  logic [1:0] cls_reads;
  logic [DATA_W-1:0] cls_opcode;

  // sum of a zero-extended index and an unsigned offset
  function automatic logic [ADDR_W-1:0] index_add(
    input logic [DATA_W-1:0] idx,
    input logic [ADDR_W-1:0] offs
  );
    index_add = ADDR_W'({{(ADDR_W-DATA_W){1'b0}}, idx} + offs);
  endfunction

  function automatic logic [ADDR_W-1:0] zext(input logic [DATA_W-1:0] v);
    zext = {{(ADDR_W-DATA_W){1'b0}}, v};
  endfunction

  function automatic cad_prefix_type prefix_of(input logic [7:0] b);
    case (b)
      CAD_Y_REGISTER_PREFIX: prefix_of = CAD_PFX_Y;
      CAD_INDIRECT_PREFIX: prefix_of = CAD_PFX_IND;
      CAD_Y_INDIRECT_INDEXED_PREFIX: prefix_of = CAD_PFX_YIND;
      default: prefix_of = CAD_PFX_NONE;
    endcase
  endfunction

  // while waiting for the opcode the classifier looks at the live byte so
  // operand and pointer counts are known in the cycle the opcode is taken
  assign cls_opcode = (s.st == CAD_ST_OPCODE) ? i_fetch_byte : s.opcode;

  cad_opcode_class u_class (
    .i_prefix(s.prefix),
    .i_opcode(cls_opcode),
    .o_mode(cls_mode),
    .o_group(cls_group),
    .o_use_y(cls_use_y),
    .o_illegal(cls_illegal),
    .o_bytes(cls_bytes),
    .o_reads(cls_reads)
  );

  logic [DATA_W-1:0] sel_index;
  logic [ADDR_W-1:0] pointer;
  logic [ADDR_W-1:0] long_operand;
  logic [ADDR_W-1:0] pointer_base;
  logic [DATA_W-1:0] rel_offset;
  logic [2:0] full_length;

  assign sel_index = cls_use_y ? i_index_y : i_index_x;
  // see RULE3 RULE4
  assign pointer = (cls_reads == 2'd2) ? {s.ptr_hi, s.ptr_lo} : zext(s.ptr_lo);
  assign long_operand = {s.byte1, s.byte2};
  // pointer address always sits in the byte right after the opcode
  assign pointer_base = zext(s.byte1); // see RULE2
  assign full_length = 3'(cls_bytes) + 3'd1 +
    ((s.prefix != CAD_PFX_NONE) ? 3'd1 : 3'd0); // see RULE24 RULE16
  // see RULE8 RULE9
  assign rel_offset = (cls_mode == CAD_REL_IND) ? s.ptr_lo :
                      (cls_mode == CAD_REL_DIR) ? s.byte1 : s.byte2;

  always_comb
  begin
    next_s = s;
    next_s.done = 1'b0;
    o_fetch_ready = 1'b0;
    o_mem_req = 1'b0;
    o_mem_addr = '0;
    case (s.st)
      CAD_ST_OPCODE:
      begin
        o_fetch_ready = 1'b1;
        if (i_fetch_valid)
        begin
          if (prefix_of(i_fetch_byte) != CAD_PFX_NONE)
          begin
            // see RULE15 RULE17
            // a second prefix replaces the first; the pair is flagged
            if (s.prefix == CAD_PFX_NONE)
              next_s.start_pc = i_fetch_pc;
            else
              next_s.double_prefix = 1'b1;
            next_s.prefix = prefix_of(i_fetch_byte);
          end
          else
          begin
            if (s.prefix == CAD_PFX_NONE)
              next_s.start_pc = i_fetch_pc;
            next_s.opcode = i_fetch_byte;
            next_s.count = 2'd0;
            if (cls_bytes != 2'd0)
              next_s.st = CAD_ST_OPERAND;
            else
              next_s.st = CAD_ST_FINISH;
          end
        end
      end
      CAD_ST_OPERAND:
      begin
        o_fetch_ready = 1'b1;
        if (i_fetch_valid)
        begin
          if (s.count == 2'd0)
            next_s.byte1 = i_fetch_byte;
          else
            next_s.byte2 = i_fetch_byte; // see RULE1
          next_s.count = s.count + 2'd1;
          if (s.count + 2'd1 == cls_bytes)
          begin
            next_s.count = 2'd0;
            // illegal forms and prefix pairs skip the pointer reads
            next_s.st = (cls_reads != 2'd0 && !cls_illegal &&
                         !s.double_prefix) ? CAD_ST_POINTER : CAD_ST_FINISH;
          end
        end
      end
      CAD_ST_POINTER:
      begin
        // word pointers are high byte first at the pointer address
        o_mem_req = 1'b1;
        o_mem_addr = pointer_base + zext({6'h00, s.count}); // see RULE2
        if (i_mem_ack)
        begin
          if (cls_reads == 2'd2 && s.count == 2'd0)
            next_s.ptr_hi = i_mem_data; // see RULE4
          else
            next_s.ptr_lo = i_mem_data; // see RULE3
          next_s.count = s.count + 2'd1;
          if (s.count + 2'd1 == cls_reads)
            next_s.st = CAD_ST_FINISH;
        end
      end
      CAD_ST_FINISH:
      begin
        next_s.done = 1'b1;
        next_s.out_opcode = s.opcode;
        next_s.mode = cls_mode;
        next_s.group = cls_group; // see RULE14
        next_s.use_y = cls_use_y;
        next_s.illegal = cls_illegal || s.double_prefix;
        next_s.length = full_length; // see RULE24
        next_s.immediate = s.byte1;
        next_s.branch = cls_mode inside {CAD_REL_DIR, CAD_REL_IND,
          CAD_BITREL_DIR, CAD_BITREL_IND}; // see RULE10
        // see RULE7
        next_s.branch_target = ADDR_W'(s.start_pc + zext({5'h00, full_length})
          + cad_sext8(rel_offset));
        case (cls_mode)
          CAD_DIR_SHORT, CAD_BIT_DIR, CAD_BITREL_DIR:
            next_s.eff_addr = zext(s.byte1);
          CAD_DIR_LONG: next_s.eff_addr = long_operand;
          CAD_IDX0: next_s.eff_addr = zext(sel_index);
          // see RULE22
          CAD_IDX_SHORT: next_s.eff_addr = index_add(sel_index, zext(s.byte1));
          CAD_IDX_LONG:
            next_s.eff_addr = index_add(sel_index, long_operand); // see RULE1
          // see RULE2 RULE3 RULE4
          CAD_IND_SHORT, CAD_IND_LONG, CAD_BIT_IND, CAD_BITREL_IND:
            next_s.eff_addr = pointer;
          // see RULE5 RULE6
          CAD_INDIDX_SHORT, CAD_INDIDX_LONG:
            next_s.eff_addr = index_add(sel_index, pointer);
          default: next_s.eff_addr = '0;
        endcase
        // see RULE23
        next_s.prefix = CAD_PFX_NONE;
        next_s.double_prefix = 1'b0;
        next_s.count = 2'd0;
        next_s.st = CAD_ST_OPCODE;
      end
      default: next_s.st = CAD_ST_OPCODE;
    endcase
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      s <= '0;
      s.st <= CAD_ST_OPCODE;
      s.prefix <= CAD_PFX_NONE;
      s.length <= 3'(CAD_LEN_RESET);
    end
    else
      s <= next_s;
  end

  assign o_done = s.done;
  assign o_opcode = s.out_opcode;
  assign o_mode = s.mode;
  assign o_group = s.group;
  assign o_use_y = s.use_y;
  assign o_illegal = s.illegal;
  assign o_length = s.length;
  assign o_eff_addr = s.eff_addr;
  assign o_immediate = s.immediate;
  assign o_branch = s.branch;
  assign o_branch_target = s.branch_target;

endmodule

// >>> verif/cad_decoder_monitor.sv
// concurrent checks on the address-mode decoder ports
`timescale 1ns/1ps
module cad_decoder_monitor
  import cad_pkg::*;
#(
  parameter int ADDR_W = CAD_ADDR_W
)
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic o_fetch_ready,
  input wire logic o_mem_req,
  input wire logic [ADDR_W-1:0] o_mem_addr,
  input wire logic i_mem_ack,
  input wire logic o_done,
  input wire cad_mode_type o_mode,
  input wire cad_group_type o_group,
  input wire logic o_illegal,
  input wire logic [2:0] o_length,
  input wire logic [ADDR_W-1:0] o_eff_addr,
  input wire logic o_branch
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  a_done_single: assert property (o_done |=> !o_done)
    else $error("done pulse longer than one cycle");
  a_ptr_hold: assert property (o_mem_req && !i_mem_ack |=>
    o_mem_req && $stable(o_mem_addr))
    else $error("pointer read dropped or moved before ack");
  a_ptr_refuse: assert property (o_mem_req |-> !o_fetch_ready)
    else $error("fetch ready during pointer read");
  a_ptr_page: assert property (o_mem_req |-> o_mem_addr <= 16'h0100)
    else $error("pointer address beyond page zero");
  a_short_range: assert property (o_done && o_mode == CAD_IND_SHORT
    |-> o_eff_addr[15:8] == 8'h00)
    else $error("short indirect outside page zero");
  a_indidx_range: assert property (o_done && o_mode == CAD_INDIDX_SHORT
    |-> o_eff_addr <= 16'h01fe)
    else $error("short indirect indexed beyond 1fe");
  a_rel_branch: assert property (o_done && o_mode inside
    {CAD_REL_DIR, CAD_REL_IND} |-> o_branch && o_eff_addr == 16'h0000)
    else $error("relative mode without branch");
  a_rel_group: assert property (o_done && !o_illegal && o_mode inside
    {CAD_REL_DIR, CAD_REL_IND} |->
    o_group inside {CAD_GRP_COND_BRANCH, CAD_GRP_JUMP})
    else $error("relative mode on a non-jump group");
  a_ind_len: assert property (o_done && !o_illegal && o_mode inside
    {CAD_IND_SHORT, CAD_IND_LONG, CAD_INDIDX_SHORT, CAD_INDIDX_LONG}
    |-> o_length == 3'd3)
    else $error("indirect length not three");
  a_len_span: assert property (o_done |-> o_length inside {[3'd1:3'd4]})
    else $error("length outside one to four");
  a_ptr_done: assert property (o_mem_req && i_mem_ack ##1 !o_mem_req
    |-> ##1 o_done)
    else $error("no result two cycles after last pointer byte");
endmodule

bind cad_decoder cad_decoder_monitor #(.ADDR_W(ADDR_W)) mon (
  .i_clock, .i_rst, .o_fetch_ready, .o_mem_req, .o_mem_addr, .i_mem_ack,
  .o_done, .o_mode, .o_group, .o_illegal, .o_length, .o_eff_addr,
  .o_branch
);

// >>> verif/cad_ptr_mem.sv
// page-zero pointer memory answering the decoder's pointer reads
`timescale 1ns/1ps
module cad_ptr_mem
(
  input wire logic i_clock,
  input wire logic i_req,
  input wire logic [15:0] i_addr,
  output logic o_ack,
  output logic [7:0] o_data
);
  logic [7:0] ram [0:511];
  logic [1:0] wait_left = 2'd0;
  logic [7:0] noise = 8'h00;

  initial
  begin
    o_ack = 1'b0;
    o_data = 8'h00;
  end

  // wait of zero to three cycles per read; data churns when not acked
  always @(posedge i_clock)
  begin
    #1;
    noise <= noise + 8'h3b;
    if (i_req && wait_left == 2'd0)
    begin
      o_ack <= 1'b1;
      o_data <= ram[i_addr[8:0]];
      wait_left <= noise[2:1];
    end
    else
    begin
      o_ack <= 1'b0;
      o_data <= noise;
      if (i_req)
        wait_left <= wait_left - 2'd1;
    end
  end
endmodule

// >>> verif/testbench.sv
// self-checking bench for the address-mode decoder
`timescale 1ns/1ps
module testbench
  import cad_pkg::*;
;
  logic i_clock, i_rst, i_fetch_valid, o_fetch_ready, o_mem_req, i_mem_ack;
  logic [7:0] i_fetch_byte, i_index_x, i_index_y, i_mem_data;
  logic [7:0] o_opcode, o_immediate, hi, lo, p, d, x, y;
  logic [15:0] i_fetch_pc, o_mem_addr, o_eff_addr, o_branch_target, pc;
  logic o_done, o_use_y, o_illegal, o_branch;
  logic [2:0] o_length;
  cad_mode_type o_mode;
  cad_group_type o_group;
  int num_errors = 0;
  int checks_done = 0;

  cad_decoder dut (.i_clock, .i_rst, .i_fetch_valid, .i_fetch_byte,
    .i_fetch_pc, .o_fetch_ready, .i_index_x, .i_index_y, .o_mem_req,
    .o_mem_addr, .i_mem_ack, .i_mem_data, .o_done, .o_opcode, .o_mode,
    .o_group, .o_use_y, .o_illegal, .o_length, .o_eff_addr, .o_immediate,
    .o_branch, .o_branch_target);
  cad_ptr_mem mem (.i_clock, .i_req(o_mem_req), .i_addr(o_mem_addr),
    .o_ack(i_mem_ack), .o_data(i_mem_data));

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp,
    input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // bytes go out msb first; each is held until taken
  task automatic run(input logic [15:0] at, input logic [31:0] code,
    input int n);
    int w;
    for (int k = 0; k < n; k++)
    begin
      i_fetch_valid <= 1'b1;
      i_fetch_byte <= code[31-8*k -: 8];
      i_fetch_pc <= at + 16'(k);
      w = 0;
      // ready is read settled, one step after the edge that set it
      while (o_fetch_ready !== 1'b1 && w < 40)
      begin
        @(posedge i_clock);
        #1;
        w++;
      end
      @(posedge i_clock);
      #1;
    end
    i_fetch_valid <= 1'b0;
    i_fetch_byte <= ~i_fetch_byte;
    w = 0;
    while (o_done !== 1'b1 && w < 40)
    begin
      @(posedge i_clock);
      #1;
      w++;
    end
    check("done", 16'h0001, 16'(o_done));
  endtask

  // illegal results only promise the flag and the length
  task automatic res(input cad_mode_type m, input logic [2:0] len,
    input logic [15:0] ea, input logic ill, input logic uy);
    check("illegal", 16'(ill), 16'(o_illegal));
    check("length", 16'(len), 16'(o_length));
    if (!ill)
    begin
      check("mode", 16'(m), 16'(o_mode));
      check("eff_addr", ea, o_eff_addr);
      check("use_y", 16'(uy), 16'(o_use_y));
    end
  endtask

  initial
  begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end

  initial
  begin
    #1000000;
    num_errors++;
    test_done();
  end

  initial
  begin
    void'($urandom(32'h03811bb1));
    i_rst = 1'b1;
    i_fetch_valid = 1'b0;
    i_fetch_byte = 8'h00;
    i_fetch_pc = 16'h0000;
    i_index_x = 8'h00;
    i_index_y = 8'h00;
    repeat (2) @(posedge i_clock);
    #1;
    i_rst <= 1'b0;
    check("ready", 16'h0001, 16'(o_fetch_ready));
    check("mem_req", 16'h0000, 16'(o_mem_req));
    run(16'h1000, {8'h40, 24'h0}, 1);
    res(CAD_INHERENT, 3'd1, 16'h0000, 0, 0);
    run(16'h1001, {8'h92, 8'hcc, 8'h10, 8'h00}, 3);
    res(CAD_INHERENT, 3'd3, 16'h0000, 1, 0);
    run(16'h1004, {8'h92, 8'hdd, 8'h10, 8'h00}, 3);
    res(CAD_INHERENT, 3'd3, 16'h0000, 1, 0);
    run(16'h1007, {8'h91, 8'hb0, 8'h10, 8'h00}, 3);
    res(CAD_INHERENT, 3'd3, 16'h0000, 1, 0);
    run(16'h100a, {8'h90, 8'h92, 8'hb0, 8'h10}, 4);
    res(CAD_INHERENT, 3'd3, 16'h0000, 1, 0);
    run(16'h100e, {8'hb0, 8'h10, 16'h0}, 2);
    res(CAD_DIR_SHORT, 3'd2, 16'h0010, 0, 0);
    run(16'h2000, {8'had, 8'h80, 16'h0}, 2);
    res(CAD_REL_DIR, 3'd2, 16'h0000, 0, 0);
    check("target", 16'h1f82, o_branch_target);
    check("group", 16'(CAD_GRP_JUMP), 16'(o_group));
    for (int i = 0; i < 8; i++)
    begin
      pc = 16'($urandom);
      {hi, lo, p} = 24'($urandom);
      x = (i == 0) ? 8'hff : 8'($urandom);
      y = 8'($urandom);
      d = (i == 0) ? 8'hff : 8'($urandom);
      i_index_x <= x;
      i_index_y <= y;
      mem.ram[{1'b0, p}] = d;
      mem.ram[{1'b0, p} + 9'd1] = hi;
      run(pc, {8'hd0, hi, lo, 8'h00}, 3);
      res(CAD_IDX_LONG, 3'd3, {hi, lo} + 16'(x), 0, 0);
      check("opcode", 16'h00d0, 16'(o_opcode));
      check("immediate", 16'(hi), 16'(o_immediate));
      run(pc, {8'h90, 8'he0, lo, 8'h00}, 3);
      res(CAD_IDX_SHORT, 3'd3, 16'(lo) + 16'(y), 0, 1);
      run(pc, {8'h92, 8'hb0, p, 8'h00}, 3);
      res(CAD_IND_SHORT, 3'd3, 16'(d), 0, 0);
      run(pc, {8'h92, 8'hc0, p, 8'h00}, 3);
      res(CAD_IND_LONG, 3'd3, {d, hi}, 0, 0);
      run(pc, {8'h92, 8'he0, p, 8'h00}, 3);
      res(CAD_INDIDX_SHORT, 3'd3, 16'(d) + 16'(x), 0, 0);
      run(pc, {8'h91, 8'he0, p, 8'h00}, 3);
      res(CAD_INDIDX_SHORT, 3'd3, 16'(d) + 16'(y), 0, 1);
      run(pc, {8'h92, 8'hd0, p, 8'h00}, 3);
      res(CAD_INDIDX_LONG, 3'd3, {d, hi} + 16'(x), 0, 0);
      run(pc, {8'h20, lo, 16'h0}, 2);
      res(CAD_REL_DIR, 3'd2, 16'h0000, 0, 0);
      check("target", pc + 16'd2 + {{8{lo[7]}}, lo}, o_branch_target);
      check("branch", 16'h0001, 16'(o_branch));
      check("group", 16'(CAD_GRP_COND_BRANCH), 16'(o_group));
      run(pc, {8'h92, 8'h20, p, 8'h00}, 3);
      res(CAD_REL_IND, 3'd3, 16'h0000, 0, 0);
      check("target", pc + 16'd3 + {{8{d[7]}}, d}, o_branch_target);
      run(pc, {8'h92, 8'h10, p, 8'h00}, 3);
      res(CAD_BIT_IND, 3'd3, 16'(d), 0, 0);
      run(pc, {8'h92, 8'h00, p, lo}, 4);
      res(CAD_BITREL_IND, 3'd4, 16'(d), 0, 0);
      check("target", pc + 16'd4 + {{8{lo[7]}}, lo}, o_branch_target);
      run(pc, {8'ha6, lo, 16'h0}, 2);
      res(CAD_IMMEDIATE, 3'd2, 16'h0000, 0, 0);
      check("immediate", 16'(lo), 16'(o_immediate));
      run(pc, {8'hc6, hi, lo, 8'h00}, 3);
      res(CAD_DIR_LONG, 3'd3, {hi, lo}, 0, 0);
    end
    test_done();
  end
endmodule
